// file: design/itc_pkg.sv
/*
  Shared constants and types of the instruction cycle timing model:
  operand kinds, instruction classes, the sequencer states and every
  clock-period and bus-cycle figure the model uses.
  Assumes one processor clock and an 8-bit data bus.
*/
package itc_pkg;

	localparam int ITC_CLK_W = 9;
	localparam int ITC_RD_W = 5;
	localparam int ITC_WR_W = 4;
	localparam int ITC_NMODES = 12;

	// Each byte-wide bus cycle spans this many clock periods
	localparam logic [1:0] ITC_BUS_LAST_PHASE = 2'h3;
	localparam logic [ITC_CLK_W-1:0] ITC_BUS_CLOCKS = 9'h004;

	typedef enum logic [3:0] {
		ITC_DATA_REGISTER_OPERAND,
		ITC_ADDRESS_REGISTER_OPERAND,
		ITC_INDIRECT,
		ITC_POSTINCREMENT,
		ITC_PREDECREMENT,
		ITC_DISPLACEMENT_INDIRECT,
		ITC_INDEX_REGISTER_INDIRECT,
		ITC_ABSOLUTE_SHORT,
		ITC_ABSOLUTE_LONG,
		ITC_PC_DISPLACEMENT,
		ITC_PC_INDEX,
		ITC_IMMEDIATE
	} itc_mode_type;

	typedef enum logic [1:0] {
		ITC_SIZE_BYTE,
		ITC_SIZE_WORD,
		ITC_SIZE_LONG
	} itc_size_type;

	typedef enum logic [3:0] {
		ITC_MOVE_LONG,
		ITC_STD_ALU,
		ITC_STD_CMP,
		ITC_EXCLUSIVE_OR_OP,
		ITC_SIGNED_MULTIPLY,
		ITC_UNSIGNED_MULTIPLY,
		ITC_SIGNED_DIVIDE,
		ITC_UNSIGNED_DIVIDE,
		ITC_IMM_ALU,
		ITC_IMM_CMP,
		ITC_QUICK,
		ITC_MOVE_QUICK
	} itc_class_type;

	typedef enum {
		ITC_IDLE,
		ITC_READ,
		ITC_WRITE,
		ITC_INTERNAL
	} itc_state_type;

	typedef struct packed {
		logic [ITC_CLK_W-1:0] clk;
		logic [ITC_RD_W-1:0] rd;
		logic [ITC_WR_W-1:0] wr;
	} itc_fig_type;

	// Effective-address figures per mode, index order of itc_mode_type
	localparam logic [ITC_CLK_W-1:0] ITC_EA_CLK_BYTE [ITC_NMODES] = '{9'h000, 9'h000,
		9'h004, 9'h004, 9'h006, 9'h00c, 9'h00e, 9'h00c, 9'h014, 9'h00c, 9'h00e, 9'h008};
	localparam logic [ITC_RD_W-1:0] ITC_EA_RD_BYTE [ITC_NMODES] = '{5'h00, 5'h00,
		5'h01, 5'h01, 5'h01, 5'h03, 5'h03, 5'h03, 5'h05, 5'h03, 5'h03, 5'h02};
	localparam logic [ITC_CLK_W-1:0] ITC_EA_CLK_WORD [ITC_NMODES] = '{9'h000, 9'h000,
		9'h008, 9'h008, 9'h00a, 9'h010, 9'h012, 9'h010, 9'h018, 9'h010, 9'h012, 9'h008};
	localparam logic [ITC_RD_W-1:0] ITC_EA_RD_WORD [ITC_NMODES] = '{5'h00, 5'h00,
		5'h02, 5'h02, 5'h02, 5'h04, 5'h04, 5'h04, 5'h06, 5'h04, 5'h04, 5'h02};
	localparam logic [ITC_CLK_W-1:0] ITC_EA_CLK_LONG [ITC_NMODES] = '{9'h000, 9'h000,
		9'h010, 9'h010, 9'h012, 9'h018, 9'h01a, 9'h018, 9'h020, 9'h018, 9'h01a, 9'h010};
	localparam logic [ITC_RD_W-1:0] ITC_EA_RD_LONG [ITC_NMODES] = '{5'h00, 5'h00,
		5'h04, 5'h04, 5'h04, 5'h06, 5'h06, 5'h06, 5'h08, 5'h06, 5'h06, 5'h04};

	// Long move: destination share added to base and source figures
	localparam itc_fig_type ITC_MOVEL_BASE = '{9'h008, 5'h02, 4'h0};
	localparam logic [ITC_CLK_W-1:0] ITC_MOVEL_DST_CLK [ITC_NMODES] = '{9'h000, 9'h000,
		9'h010, 9'h010, 9'h010, 9'h018, 9'h01a, 9'h018, 9'h020, 9'h000, 9'h000, 9'h000};
	localparam logic [ITC_RD_W-1:0] ITC_MOVEL_DST_RD [ITC_NMODES] = '{5'h00, 5'h00,
		5'h00, 5'h00, 5'h00, 5'h02, 5'h02, 5'h02, 5'h04, 5'h00, 5'h00, 5'h00};
	localparam logic [ITC_WR_W-1:0] ITC_MOVEL_DST_WR = 4'h4;

	// Standard instructions
	localparam itc_fig_type ITC_STD_DN_SHORT = '{9'h008, 5'h02, 4'h0};
	localparam itc_fig_type ITC_STD_DN_LONG = '{9'h00a, 5'h02, 4'h0};
	localparam itc_fig_type ITC_STD_DN_LONG_RI = '{9'h00c, 5'h02, 4'h0};
	localparam itc_fig_type ITC_EOR_DN_LONG = '{9'h00c, 5'h02, 4'h0};
	localparam itc_fig_type ITC_STD_AN_WORD = '{9'h00c, 5'h02, 4'h0};
	localparam itc_fig_type ITC_CMP_AN_WORD = '{9'h00a, 5'h02, 4'h0};
	localparam itc_fig_type ITC_STD_M_BYTE = '{9'h00c, 5'h02, 4'h1};
	localparam itc_fig_type ITC_STD_M_WORD = '{9'h010, 5'h02, 4'h2};
	localparam itc_fig_type ITC_STD_M_LONG = '{9'h018, 5'h02, 4'h4};
	localparam itc_fig_type ITC_MUL_BASE = '{9'h02a, 5'h02, 4'h0};
	localparam itc_fig_type ITC_SDIV_WORST = '{9'h0a2, 5'h02, 4'h0};
	localparam itc_fig_type ITC_UDIV_WORST = '{9'h090, 5'h02, 4'h0};

	// Immediate instructions
	localparam itc_fig_type ITC_IMM_DN_SHORT = '{9'h010, 5'h04, 4'h0};
	localparam itc_fig_type ITC_IMM_DN_LONG = '{9'h01c, 5'h06, 4'h0};
	localparam itc_fig_type ITC_CMPI_DN_LONG = '{9'h01a, 5'h06, 4'h0};
	localparam itc_fig_type ITC_IMM_M_BYTE = '{9'h014, 5'h04, 4'h1};
	localparam itc_fig_type ITC_IMM_M_WORD = '{9'h018, 5'h04, 4'h2};
	localparam itc_fig_type ITC_IMM_M_LONG = '{9'h028, 5'h06, 4'h4};
	localparam itc_fig_type ITC_CMPI_M_SHORT = '{9'h010, 5'h04, 4'h0};
	localparam itc_fig_type ITC_CMPI_M_LONG = '{9'h018, 5'h06, 4'h0};
	localparam itc_fig_type ITC_QUICK_SHORT = '{9'h008, 5'h02, 4'h0};
	localparam itc_fig_type ITC_QUICK_REG = '{9'h00c, 5'h02, 4'h0};

endpackage

// file: design/itc_mul_count.sv
/*
  Multiply operand weight: number of ones for the unsigned form, number
  of 10/01 pairs in the source extended by a zero below it for the signed.
  Purely combinational; the caller registers what it needs.
*/
`timescale 1ns/1ps
module itc_mul_count (
	// Operand
	input wire logic [15:0] operand,
	input wire logic signedForm,
	// Weight
	output logic [4:0] weight
);
	import itc_pkg::*;

	logic [16:0] extended;

	always_comb begin
		extended = {operand, 1'b0};
		weight = 5'h00;
		for (int i = 0; i < 16; i++) begin
			if (signedForm) begin
				weight = weight + {4'h0, extended[i+1] ^ extended[i]};
			end else begin
				weight = weight + {4'h0, operand[i]};
			end
		end
	end

endmodule

// file: design/itc_timing.sv
/*
  Instruction cycle timing model. A request names the instruction class,
  size and operand kinds; the block works out clock periods and bus
  read/write counts, then plays them out as 4-clock bus cycles.
  Assumes requests come from logic on sys_clk and are held only while start.
*/
`timescale 1ns/1ps
// Summary of operation
// - Long move totals cover instruction fetch, operand reads and operand writes.
// - Every timed instruction reports its bus read and write counts next to its clocks.
// - Standard instruction figures include operation, result store and next fetch.
// - Immediate figures include immediate fetch, operation, store and next fetch.
// - Marked entries add effective-address clocks and reads kind by kind; the effective address adds no writes.
// - Indexed forms take the same time whatever the index register size.
// - Long moves into indirect destinations take 40, 42 or 48 clocks by source.
// - Long moves to a data register take 34, 32 or 40 clocks by source, no writes.
// - Long moves to absolute long take 66, 64 or 72 clocks by source.
// - Multiply takes 42 plus twice the operand weight clocks.
// - A 10-clock long standard ALU op becomes 12 with register or immediate operand; compare stays at 10.
// - Exclusive-or into a data register accepts only a data register source.
// - Divide best and worst times differ by under ten percent.
module itc_timing (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Request
	input wire logic start,
	input wire itc_pkg::itc_class_type opClass,
	input wire itc_pkg::itc_size_type opSize,
	input wire itc_pkg::itc_mode_type srcMode,
	input wire itc_pkg::itc_mode_type dstMode,
	input wire logic [15:0] mulOperand,
	output logic ready,
	// Figures
	output logic [itc_pkg::ITC_CLK_W-1:0] clocks,
	output logic [itc_pkg::ITC_RD_W-1:0] reads,
	output logic [itc_pkg::ITC_WR_W-1:0] writes,
	output logic illegal,
	output logic done,
	// Bus activity
	output logic busRead,
	output logic busWrite,
	output logic busy
);
	import itc_pkg::*;

	typedef struct packed {
		itc_state_type st;
		logic [1:0] phase;
		logic [ITC_RD_W-1:0] readsLeft;
		logic [ITC_WR_W-1:0] writesLeft;
		logic [ITC_CLK_W-1:0] idleLeft;
		logic [ITC_CLK_W-1:0] clocks;
		logic [ITC_RD_W-1:0] reads;
		logic [ITC_WR_W-1:0] writes;
		logic illegal;
		logic done;
		logic busRead;
		logic busWrite;
	} itc_regs_type;

	itc_regs_type r;
	itc_regs_type next_r;
	logic [4:0] mulWeight;
	itc_fig_type fig;
	logic bad;

	itc_mul_count mulCount (
		.operand(mulOperand),
		.signedForm(opClass == ITC_SIGNED_MULTIPLY),
		.weight(mulWeight)
	);

	function automatic itc_fig_type addFig(itc_fig_type a, itc_fig_type b);
		itc_fig_type s;
		s.clk = a.clk + b.clk;
		s.rd = a.rd + b.rd;
		s.wr = a.wr + b.wr;
		return s;
	endfunction

	// Index modes carry one figure; no index size enters the lookup
	function automatic itc_fig_type eaFig(itc_mode_type m, itc_size_type sz);
		itc_fig_type f;
		f.wr = '0;
		f.clk = (sz == ITC_SIZE_BYTE) ? ITC_EA_CLK_BYTE[m] :
			(sz == ITC_SIZE_WORD) ? ITC_EA_CLK_WORD[m] : ITC_EA_CLK_LONG[m];
		f.rd = (sz == ITC_SIZE_BYTE) ? ITC_EA_RD_BYTE[m] :
			(sz == ITC_SIZE_WORD) ? ITC_EA_RD_WORD[m] : ITC_EA_RD_LONG[m];
		return f;
	endfunction
	function automatic logic isReg(itc_mode_type m);
		return m == ITC_DATA_REGISTER_OPERAND || m == ITC_ADDRESS_REGISTER_OPERAND;
	endfunction
	function automatic logic notWritable(itc_mode_type m);
		return m == ITC_PC_DISPLACEMENT || m == ITC_PC_INDEX || m == ITC_IMMEDIATE;
	endfunction

	// Figures of the requested instruction
	always_comb begin
		itc_fig_type base;
		itc_fig_type ea;
		itc_fig_type dst;
		base = '0;
		dst = '0;
		bad = 1'b0;
		ea = eaFig(srcMode, opSize);
		unique case (opClass)
			ITC_MOVE_LONG: begin
				// Base fetch, long source read, destination write share
				ea = eaFig(srcMode, ITC_SIZE_LONG);
				dst.clk = ITC_MOVEL_DST_CLK[dstMode];
				dst.rd = ITC_MOVEL_DST_RD[dstMode];
				dst.wr = isReg(dstMode) ? '0 : ITC_MOVEL_DST_WR;
				base = addFig(ITC_MOVEL_BASE, dst);
				bad = notWritable(dstMode);
			end
			ITC_STD_ALU, ITC_STD_CMP, ITC_EXCLUSIVE_OR_OP: begin
				if (dstMode == ITC_DATA_REGISTER_OPERAND) begin
					if (opSize != ITC_SIZE_LONG) begin
						base = ITC_STD_DN_SHORT;
					end else if (opClass == ITC_EXCLUSIVE_OR_OP) begin
						base = ITC_EOR_DN_LONG;
					end else if (opClass == ITC_STD_ALU &&
						(isReg(srcMode) || srcMode == ITC_IMMEDIATE)) begin
						base = ITC_STD_DN_LONG_RI;
					end else begin
						base = ITC_STD_DN_LONG;
					end
					bad = opClass == ITC_EXCLUSIVE_OR_OP &&
						srcMode != ITC_DATA_REGISTER_OPERAND;
				end else if (dstMode == ITC_ADDRESS_REGISTER_OPERAND) begin
					if (opSize == ITC_SIZE_WORD) begin
						base = (opClass == ITC_STD_CMP) ? ITC_CMP_AN_WORD : ITC_STD_AN_WORD;
					end else if (opClass == ITC_STD_ALU && (isReg(srcMode) ||
						srcMode == ITC_IMMEDIATE)) begin
						base = ITC_STD_DN_LONG_RI;
					end else begin
						base = ITC_STD_DN_LONG;
					end
					bad = opSize == ITC_SIZE_BYTE || opClass == ITC_EXCLUSIVE_OR_OP;
				end else begin
					// Register source, memory destination: the destination is the ea
					ea = eaFig(dstMode, opSize);
					unique case (opSize)
						ITC_SIZE_BYTE: base = ITC_STD_M_BYTE;
						ITC_SIZE_WORD: base = ITC_STD_M_WORD;
						default: base = ITC_STD_M_LONG;
					endcase
					bad = opClass == ITC_STD_CMP || notWritable(dstMode) || !isReg(srcMode);
				end
			end
			ITC_SIGNED_MULTIPLY, ITC_UNSIGNED_MULTIPLY: begin
				ea = eaFig(srcMode, ITC_SIZE_WORD);
				base = ITC_MUL_BASE;
				base.clk = ITC_MUL_BASE.clk + {3'h0, mulWeight, 1'b0};
				bad = dstMode != ITC_DATA_REGISTER_OPERAND;
			end
			ITC_SIGNED_DIVIDE, ITC_UNSIGNED_DIVIDE: begin
				// Worst case stands for every operand: the spread is small
				ea = eaFig(srcMode, ITC_SIZE_WORD);
				base = (opClass == ITC_SIGNED_DIVIDE) ? ITC_SDIV_WORST : ITC_UDIV_WORST;
				bad = dstMode != ITC_DATA_REGISTER_OPERAND;
			end
			ITC_IMM_ALU, ITC_IMM_CMP: begin
				if (dstMode == ITC_DATA_REGISTER_OPERAND) begin
					ea = '0;
					base = (opSize != ITC_SIZE_LONG) ? ITC_IMM_DN_SHORT :
						(opClass == ITC_IMM_CMP) ? ITC_CMPI_DN_LONG : ITC_IMM_DN_LONG;
				end else begin
					ea = eaFig(dstMode, opSize);
					if (opClass == ITC_IMM_CMP) begin
						base = (opSize == ITC_SIZE_LONG) ? ITC_CMPI_M_LONG : ITC_CMPI_M_SHORT;
					end else begin
						unique case (opSize)
							ITC_SIZE_BYTE: base = ITC_IMM_M_BYTE;
							ITC_SIZE_WORD: base = ITC_IMM_M_WORD;
							default: base = ITC_IMM_M_LONG;
						endcase
					end
					bad = dstMode == ITC_ADDRESS_REGISTER_OPERAND || notWritable(dstMode);
				end
			end
			ITC_QUICK: begin
				ea = '0;
				if (dstMode == ITC_DATA_REGISTER_OPERAND) begin
					base = (opSize == ITC_SIZE_LONG) ? ITC_QUICK_REG : ITC_QUICK_SHORT;
				end else if (dstMode == ITC_ADDRESS_REGISTER_OPERAND) begin
					base = ITC_QUICK_REG;
					bad = opSize == ITC_SIZE_BYTE;
				end else begin
					ea = eaFig(dstMode, opSize);
					unique case (opSize)
						ITC_SIZE_BYTE: base = ITC_STD_M_BYTE;
						ITC_SIZE_WORD: base = ITC_STD_M_WORD;
						default: base = ITC_STD_M_LONG;
					endcase
					bad = notWritable(dstMode);
				end
			end
			ITC_MOVE_QUICK: begin
				ea = '0;
				base = ITC_QUICK_SHORT;
				bad = dstMode != ITC_DATA_REGISTER_OPERAND;
			end
			default: begin
				ea = '0;
				bad = 1'b1;
			end
		endcase
		fig = addFig(base, ea);
	end

	// Sequencer: reads, then writes, then the remaining internal clocks
	always_comb begin
		logic [ITC_CLK_W-1:0] busClocks;
		busClocks = ITC_BUS_CLOCKS * ({4'h0, fig.rd} + {5'h00, fig.wr});
		next_r = r;
		next_r.done = 1'b0;
		next_r.busRead = 1'b0;
		next_r.busWrite = 1'b0;
		unique case (r.st)
			ITC_IDLE: begin
				if (start) begin
					next_r.illegal = bad;
					next_r.clocks = bad ? '0 : fig.clk;
					next_r.reads = bad ? '0 : fig.rd;
					next_r.writes = bad ? '0 : fig.wr;
					next_r.readsLeft = fig.rd;
					next_r.writesLeft = fig.wr;
					// Tables never undercut their bus time; clamp guards odd requests
					next_r.idleLeft = (fig.clk > busClocks) ? fig.clk - busClocks : '0;
					next_r.phase = '0;
					if (bad) begin
						next_r.done = 1'b1;
					end else if (fig.rd != '0) begin
						next_r.st = ITC_READ;
						next_r.busRead = 1'b1;
					end else if (fig.wr != '0) begin
						next_r.st = ITC_WRITE;
						next_r.busWrite = 1'b1;
					end else if (next_r.idleLeft != '0) begin
						next_r.st = ITC_INTERNAL;
					end else begin
						next_r.done = 1'b1;
					end
				end
			end
			ITC_READ, ITC_WRITE: begin
				next_r.phase = r.phase + 2'h1;
				if (r.phase == ITC_BUS_LAST_PHASE) begin
					next_r.readsLeft = r.readsLeft - {4'h0, r.st == ITC_READ};
					next_r.writesLeft = r.writesLeft - {3'h0, r.st == ITC_WRITE};
					if (r.st == ITC_READ && r.readsLeft > 5'h01) begin
						next_r.busRead = 1'b1;
					end else if (r.writesLeft > ((r.st == ITC_WRITE) ? 4'h1 : 4'h0)) begin
						next_r.st = ITC_WRITE;
						next_r.busWrite = 1'b1;
					end else if (r.idleLeft != '0) begin
						next_r.st = ITC_INTERNAL;
					end else begin
						next_r.st = ITC_IDLE;
						next_r.done = 1'b1;
					end
				end
			end
			ITC_INTERNAL: begin
				next_r.idleLeft = r.idleLeft - 9'h001;
				if (r.idleLeft == 9'h001) begin
					next_r.st = ITC_IDLE;
					next_r.done = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			r <= '{st: ITC_IDLE, default: '0};
		end else begin
			r <= next_r;
		end
	end

	assign ready = r.st == ITC_IDLE;
	assign busy = r.st != ITC_IDLE;
	assign clocks = r.clocks;
	assign reads = r.reads;
	assign writes = r.writes;
	assign illegal = r.illegal;
	assign done = r.done;
	assign busRead = r.busRead;
	assign busWrite = r.busWrite;

endmodule

// file: dv/itc_timing_monitor.sv
/*
  Port checker for itc_timing: figures, playback length and bus pulse spacing.
  Assumes one clock, sync active-high reset, bound from the bench.
*/
`timescale 1ns/1ps
module itc_timing_monitor (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Request
	input wire logic start,
	input wire itc_pkg::itc_class_type opClass,
	input wire itc_pkg::itc_size_type opSize,
	input wire itc_pkg::itc_mode_type srcMode,
	input wire itc_pkg::itc_mode_type dstMode,
	input wire logic [15:0] mulOperand,
	input wire logic ready,
	// Figures
	input wire logic [itc_pkg::ITC_CLK_W-1:0] clocks,
	input wire logic [itc_pkg::ITC_RD_W-1:0] reads,
	input wire logic [itc_pkg::ITC_WR_W-1:0] writes,
	input wire logic illegal,
	input wire logic done,
	// Bus activity
	input wire logic busRead,
	input wire logic busWrite,
	input wire logic busy
);
	import itc_pkg::*;
	logic take;
	logic [ITC_CLK_W-1:0] busyCount;
	assign take = start && ready;
	// Busy cycles since the last accepted request
	always_ff @(posedge sys_clk) begin
		if (sys_rst || take) begin
			busyCount <= 9'h000;
		end else if (busy) begin
			busyCount <= busyCount + 9'h001;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	property p_accept;
		take |=> (illegal ? (done && !busy) : (busy && busRead));
	endproperty
	a_accept: assert property (p_accept) else $error("bad start of playback");
	property p_illegal;
		illegal |-> clocks == 9'h000 && reads == 5'h00 && writes == 4'h0 && !busRead;
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal request shows figures");
	property p_spacing;
		(busRead || busWrite) |=> !(busRead || busWrite) [*3];
	endproperty
	a_spacing: assert property (p_spacing) else $error("bus cycle shorter than four clocks");
	property p_length;
		done |-> busyCount == clocks;
	endproperty
	a_length: assert property (p_length) else $error("busy span differs from clocks");
	property p_stable;
		busy |=> $stable(clocks) && $stable(reads) && $stable(writes);
	endproperty
	a_stable: assert property (p_stable) else $error("figures moved during playback");
	property p_mul;
		take && opClass == ITC_UNSIGNED_MULTIPLY && srcMode == ITC_DATA_REGISTER_OPERAND
			|=> clocks == 9'h02a + 9'(2 * $countones($past(mulOperand)));
	endproperty
	a_mul: assert property (p_mul) else $error("multiply clocks wrong");
	property p_movel;
		take && opClass == ITC_MOVE_LONG && srcMode == ITC_ABSOLUTE_LONG
			&& dstMode == ITC_ABSOLUTE_LONG |=> clocks == 9'h048 && reads == 5'h0e && writes == 4'h4;
	endproperty
	a_movel: assert property (p_movel) else $error("long move figures wrong");
	property p_room;
		done && !illegal |-> clocks >= 9'({reads, 2'b00}) + 9'({writes, 2'b00});
	endproperty
	a_room: assert property (p_room) else $error("clocks below bus cycle time");
	c_illegal: cover property (take ##1 illegal);
	c_write: cover property (busWrite);
	c_mul: cover property (take && opClass == ITC_SIGNED_MULTIPLY);
endmodule

// file: dv/itc_byte_mem.sv
/*
  Byte-wide memory on the far side: counts the read and write cycles
  issued for one instruction. Assumes the bench clears it per request.
*/
`timescale 1ns/1ps
module itc_byte_mem (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Bus activity
	input wire logic take,
	input wire logic busRead,
	input wire logic busWrite,
	// Counts
	output logic [4:0] readCount,
	output logic [3:0] writeCount
);
	always_ff @(posedge sys_clk) begin
		if (sys_rst || take) begin
			readCount <= 5'h00;
			writeCount <= 4'h0;
		end else begin
			readCount <= readCount + 5'(busRead);
			writeCount <= writeCount + 4'(busWrite);
		end
	end
endmodule

// file: dv/itc_timing_tb.sv
/*
  Self-checking bench for itc_timing: long moves, multiply, standard and
  immediate figures with playback. Assumes a 200 MHz clock.
*/
`timescale 1ns/1ps
module itc_timing_tb;
	import itc_pkg::*;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic start = 1'b0;
	itc_class_type opClass = ITC_MOVE_LONG;
	itc_size_type opSize = ITC_SIZE_LONG;
	itc_mode_type srcMode = ITC_DATA_REGISTER_OPERAND;
	itc_mode_type dstMode = ITC_DATA_REGISTER_OPERAND;
	logic [15:0] mulOperand = 16'h0000;
	logic ready, illegal, done, busRead, busWrite, busy;
	logic [ITC_CLK_W-1:0] clocks;
	logic [ITC_RD_W-1:0] reads;
	logic [ITC_WR_W-1:0] writes;
	logic [4:0] readCount;
	logic [3:0] writeCount;
	int fails = 0;
	int tests_run = 0;
	always #2.5 sys_clk = ~sys_clk;
	itc_timing dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .start(start), .opClass(opClass),
		.opSize(opSize), .srcMode(srcMode), .dstMode(dstMode), .mulOperand(mulOperand),
		.ready(ready), .clocks(clocks), .reads(reads), .writes(writes), .illegal(illegal),
		.done(done), .busRead(busRead), .busWrite(busWrite), .busy(busy));
	itc_byte_mem mem (.sys_clk(sys_clk), .sys_rst(sys_rst), .take(start && ready),
		.busRead(busRead), .busWrite(busWrite), .readCount(readCount), .writeCount(writeCount));
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chkNum(input logic [8:0] got, input logic [8:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Multiply clocks from the weight of the source, worked out bit by bit
	function automatic logic [8:0] mulClocks(input logic [15:0] op, input logic sgn);
		logic [16:0] ext;
		int n;
		ext = {op, 1'b0};
		n = 0;
		for (int i = 0; i < 16; i++) n += sgn ? int'(ext[i] != ext[i+1]) : int'(op[i]);
		return 9'h02a + 9'(2 * n);
	endfunction
	// Entered at a falling edge with ready high; returns at the first falling edge of sys_clk that sees done high
	task automatic doOp(input itc_class_type c, input itc_size_type s, input itc_mode_type sm,
		input itc_mode_type dm, input logic [15:0] m, input logic [8:0] eClk,
		input logic [4:0] eRd, input logic [3:0] eWr, input logic eIll);
		int n;
		start = 1'b1;
		opClass = c;
		opSize = s;
		srcMode = sm;
		dstMode = dm;
		mulOperand = m;
		@(negedge sys_clk);
		start = 1'b0;
		mulOperand = ~m;
		chkNum(clocks, eClk);
		chkNum(9'(reads), 9'(eRd));
		chkNum(9'(writes), 9'(eWr));
		chkNum(9'(illegal), 9'(eIll));
		n = 0;
		for (int i = 0; i < 400 && done !== 1'b1; i++) begin
			if (busy === 1'b1) n++;
			@(negedge sys_clk);
		end
		chkNum(9'(done), 9'h001);
		chkNum(9'(n), eClk);
		chkNum(9'(readCount), 9'(eRd));
		chkNum(9'(writeCount), 9'(eWr));
	endtask
	initial begin
		#200000;
		fails++;
		results();
	end
	initial begin
		itc_mode_type mlSrc [9] = '{ITC_POSTINCREMENT, ITC_PREDECREMENT,
			ITC_DISPLACEMENT_INDIRECT, ITC_INDEX_REGISTER_INDIRECT, ITC_ABSOLUTE_SHORT,
			ITC_ABSOLUTE_LONG, ITC_INDEX_REGISTER_INDIRECT, ITC_ABSOLUTE_SHORT, ITC_ABSOLUTE_LONG};
		itc_mode_type mlDst [9] = '{ITC_INDIRECT, ITC_INDIRECT, ITC_INDIRECT,
			ITC_DATA_REGISTER_OPERAND, ITC_DATA_REGISTER_OPERAND, ITC_DATA_REGISTER_OPERAND,
			ITC_ABSOLUTE_LONG, ITC_ABSOLUTE_LONG, ITC_ABSOLUTE_LONG};
		logic [8:0] mlClk [9] = '{9'h028, 9'h02a, 9'h030, 9'h022, 9'h020, 9'h028, 9'h042,
			9'h040, 9'h048};
		logic [4:0] mlRd [9] = '{5'h06, 5'h06, 5'h08, 5'h08, 5'h08, 5'h0a, 5'h0c, 5'h0c, 5'h0e};
		logic [3:0] mlWr [9] = '{4'h4, 4'h4, 4'h4, 4'h0, 4'h0, 4'h0, 4'h4, 4'h4, 4'h4};
		int k;
		logic [15:0] op;
		logic sgn;
		void'($urandom(15));
		repeat (8) @(negedge sys_clk);
		sys_rst = 1'b0;
		@(negedge sys_clk);
		for (int j = 0; j < 18; j++) begin
			k = (j < 9) ? j : int'($urandom % 9);
			doOp(ITC_MOVE_LONG, ITC_SIZE_LONG, mlSrc[k], mlDst[k], 16'h0000, mlClk[k],
				mlRd[k], mlWr[k], 1'b0);
		end
		$display("test long move done");
		doOp(ITC_SIGNED_MULTIPLY, ITC_SIZE_WORD, ITC_DATA_REGISTER_OPERAND,
			ITC_DATA_REGISTER_OPERAND, 16'h5555, 9'h04a, 5'h02, 4'h0, 1'b0);
		doOp(ITC_SIGNED_MULTIPLY, ITC_SIZE_WORD, ITC_INDIRECT,
			ITC_DATA_REGISTER_OPERAND, 16'h0001, 9'h036, 5'h04, 4'h0, 1'b0);
		for (int j = 0; j < 20; j++) begin
			op = 16'($urandom);
			sgn = 1'($urandom);
			doOp(sgn ? ITC_SIGNED_MULTIPLY : ITC_UNSIGNED_MULTIPLY, ITC_SIZE_WORD,
				ITC_DATA_REGISTER_OPERAND, ITC_DATA_REGISTER_OPERAND, op, mulClocks(op, sgn),
				5'h02, 4'h0, 1'b0);
		end
		$display("test multiply done");
		doOp(ITC_STD_ALU, ITC_SIZE_LONG, ITC_DATA_REGISTER_OPERAND, ITC_DATA_REGISTER_OPERAND,
			16'h0000, 9'h00c, 5'h02, 4'h0, 1'b0);
		doOp(ITC_STD_ALU, ITC_SIZE_LONG, ITC_INDIRECT, ITC_DATA_REGISTER_OPERAND,
			16'h0000, 9'h01a, 5'h06, 4'h0, 1'b0);
		doOp(ITC_STD_ALU, ITC_SIZE_BYTE, ITC_DATA_REGISTER_OPERAND, ITC_INDIRECT,
			16'h0000, 9'h010, 5'h03, 4'h1, 1'b0);
		doOp(ITC_STD_CMP, ITC_SIZE_LONG, ITC_DATA_REGISTER_OPERAND, ITC_DATA_REGISTER_OPERAND,
			16'h0000, 9'h00a, 5'h02, 4'h0, 1'b0);
		doOp(ITC_STD_ALU, ITC_SIZE_WORD, ITC_ABSOLUTE_SHORT, ITC_ADDRESS_REGISTER_OPERAND,
			16'h0000, 9'h01c, 5'h06, 4'h0, 1'b0);
		doOp(ITC_STD_CMP, ITC_SIZE_BYTE, ITC_DATA_REGISTER_OPERAND, ITC_INDIRECT,
			16'h0000, 9'h000, 5'h00, 4'h0, 1'b1);
		doOp(ITC_EXCLUSIVE_OR_OP, ITC_SIZE_WORD, ITC_INDIRECT, ITC_DATA_REGISTER_OPERAND,
			16'h0000, 9'h000, 5'h00, 4'h0, 1'b1);
		doOp(ITC_EXCLUSIVE_OR_OP, ITC_SIZE_WORD, ITC_DATA_REGISTER_OPERAND,
			ITC_DATA_REGISTER_OPERAND, 16'h0000, 9'h008, 5'h02, 4'h0, 1'b0);
		doOp(ITC_SIGNED_DIVIDE, ITC_SIZE_WORD, ITC_DATA_REGISTER_OPERAND,
			ITC_DATA_REGISTER_OPERAND, 16'h0000, 9'h0a2, 5'h02, 4'h0, 1'b0);
		doOp(ITC_UNSIGNED_DIVIDE, ITC_SIZE_WORD, ITC_DATA_REGISTER_OPERAND,
			ITC_DATA_REGISTER_OPERAND, 16'hffff, 9'h090, 5'h02, 4'h0, 1'b0);
		doOp(ITC_IMM_ALU, ITC_SIZE_LONG, ITC_IMMEDIATE, ITC_DATA_REGISTER_OPERAND,
			16'h0000, 9'h01c, 5'h06, 4'h0, 1'b0);
		doOp(ITC_IMM_ALU, ITC_SIZE_BYTE, ITC_IMMEDIATE, ITC_INDIRECT,
			16'h0000, 9'h018, 5'h05, 4'h1, 1'b0);
		doOp(ITC_IMM_CMP, ITC_SIZE_LONG, ITC_IMMEDIATE, ITC_POSTINCREMENT,
			16'h0000, 9'h028, 5'h0a, 4'h0, 1'b0);
		doOp(ITC_QUICK, ITC_SIZE_LONG, ITC_IMMEDIATE, ITC_DISPLACEMENT_INDIRECT,
			16'h0000, 9'h030, 5'h08, 4'h4, 1'b0);
		doOp(ITC_QUICK, ITC_SIZE_WORD, ITC_IMMEDIATE, ITC_ADDRESS_REGISTER_OPERAND,
			16'h0000, 9'h00c, 5'h02, 4'h0, 1'b0);
		doOp(ITC_MOVE_QUICK, ITC_SIZE_LONG, ITC_IMMEDIATE, ITC_DATA_REGISTER_OPERAND,
			16'h0000, 9'h008, 5'h02, 4'h0, 1'b0);
		doOp(ITC_MOVE_QUICK, ITC_SIZE_LONG, ITC_IMMEDIATE, ITC_ADDRESS_REGISTER_OPERAND,
			16'h0000, 9'h000, 5'h00, 4'h0, 1'b1);
		doOp(ITC_MOVE_LONG, ITC_SIZE_LONG, ITC_DATA_REGISTER_OPERAND, ITC_PC_DISPLACEMENT,
			16'h0000, 9'h000, 5'h00, 4'h0, 1'b1);
		$display("test standard and immediate done");
		results();
	end
endmodule
bind itc_timing itc_timing_monitor u_mon (.sys_clk(sys_clk), .sys_rst(sys_rst), .start(start),
	.opClass(opClass), .opSize(opSize), .srcMode(srcMode), .dstMode(dstMode),
	.mulOperand(mulOperand), .ready(ready), .clocks(clocks), .reads(reads), .writes(writes),
	.illegal(illegal), .done(done), .busRead(busRead), .busWrite(busWrite), .busy(busy));
